// >>> inc/fpp_regs.svh
// Register addresses, codes, reset values and timing counts for the flash protection programmer
`ifndef FPP_REGS_SVH
`define FPP_REGS_SVH

// Special function register addresses
`define FPP_SFR_CMD 8'hB9
`define FPP_SFR_PTR_HIGH 8'hC7
`define FPP_SFR_PTR_LOW 8'hC6
`define FPP_SFR_WP_MID 8'hC3
`define FPP_SFR_WP_LOW 8'hC4
`define FPP_SFR_RD_PROT 8'hC5
`define FPP_SFR_PROT_KEY 8'hC1
`define FPP_SFR_ACC_KEY 8'hC2
`define FPP_SFR_DATA 8'hBC

// Flash command codes
`define FPP_CMD_WRITE 8'h01
`define FPP_CMD_ERASE_PAGE 8'h02
`define FPP_CMD_ERASE_ALL 8'h03
`define FPP_CMD_READ 8'h04
`define FPP_CMD_ERASE_WRITE 8'h05
`define FPP_CMD_PROTECT 8'h08
`define FPP_CMD_VERIFY 8'h0F

// Keys and values
`define FPP_ACCESS_KEY 8'h3B
`define FPP_ERASED 8'hFF
`define FPP_SFR_RESET 8'h00
`define FPP_BLOCKED_DATA 8'h00

// Protection byte locations in the last page
`define FPP_ADDR_WP_3 14'h3FFF
`define FPP_ADDR_WP_2 14'h3FFE
`define FPP_ADDR_WP_1 14'h3FFD
`define FPP_ADDR_WP_0 14'h3FFC
`define FPP_ADDR_RP 14'h3FFB
`define FPP_ADDR_KEY 14'h3FFA

// Download kernel commands
`define FPP_KCMD_LOAD 8'h49
`define FPP_KCMD_STORE 8'h46

// Wishbone offsets of the controller
`define FPP_WB_KCMD 8'h00
`define FPP_WB_STATUS 8'h04
`define FPP_WB_CTRL 8'h08
`define FPP_WB_DATA 8'h0C

// Timing, in ns, and derived clock cycles
`define FPP_CLK_PERIOD_NS 100
`define FPP_T_WRITE_NS 30000
`define FPP_T_PAGE_NS 20000000
`define FPP_T_ALL_NS 200000000
`define FPP_T_ERASE_WRITE_NS 21000000
`define FPP_T_READ_NS 100
`define FPP_PROT_BYTES 6
`define FPP_CYC_WRITE ((`FPP_T_WRITE_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_CYC_PAGE ((`FPP_T_PAGE_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_CYC_ALL ((`FPP_T_ALL_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_CYC_ERASE_WRITE ((`FPP_T_ERASE_WRITE_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_CYC_READ ((`FPP_T_READ_NS + `FPP_CLK_PERIOD_NS - 1) / `FPP_CLK_PERIOD_NS)
`define FPP_CYC_PROTECT (`FPP_CYC_WRITE * `FPP_PROT_BYTES)

`endif

// >>> inc/fpp_pkg.sv
// Types shared by both ends of the flash protection programmer
package fpp_pkg;
  typedef logic [7:0] fpp_byte_t;
  typedef logic [13:0] fpp_addr_t;
  typedef enum logic [2:0]
  {
    FPP_H_IDLE = 3'b001,
    FPP_H_ISSUE = 3'b010,
    FPP_H_WAIT = 3'b100
  } fpp_host_state_t;
endpackage

// >>> inc/fpp_if.sv
// Special function register link between controller and flash protection device
`timescale 1ns/1ps
interface fpp_if;
  logic sfr_wr;
  fpp_pkg::fpp_byte_t sfr_addr;
  fpp_pkg::fpp_byte_t sfr_wdata;
  fpp_pkg::fpp_byte_t flash_data;
  logic stall;
  logic mass_erase;
  logic serial_dl_enable_n;
  modport dev
  (
    input sfr_wr, sfr_addr, sfr_wdata, mass_erase, serial_dl_enable_n,
    output flash_data, stall
  );
  modport host
  (
    output sfr_wr, sfr_addr, sfr_wdata, mass_erase, serial_dl_enable_n,
    input flash_data, stall
  );
endinterface

// >>> verilog/fpp_busy_timer.sv
// Down counter that holds busy for a loaded number of cycles
`timescale 1ns/1ps
module fpp_busy_timer #(
  parameter int WIDTH = 22
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_cycles,
  output logic o_busy
);
  logic [WIDTH-1:0] count;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      count <= '0;
      o_busy <= 1'b0;
    end
    else if (i_load)
    begin
      count <= i_cycles;
      o_busy <= (i_cycles != '0);
    end
    else if (count != '0)
    begin
      count <= count - WIDTH'(1);
      o_busy <= (count > WIDTH'(1));
    end
  end
endmodule // fpp_busy_timer

// >>> verilog/fpp_device.sv
// Flash protection device: staging registers, protection programming, enforcement and stall
`include "fpp_regs.svh"
`timescale 1ns/1ps
module fpp_device #(
  parameter int CYC_PAGE = `FPP_CYC_PAGE,
  parameter int CYC_ALL = `FPP_CYC_ALL,
  parameter int CYC_ERASE_WRITE = `FPP_CYC_ERASE_WRITE,
  parameter int TW = 22
) (
  input wire logic i_clk,
  input wire logic i_rst,
  fpp_if.dev bus,
  input wire logic i_rd_en,
  input wire logic [13:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_rd_blocked,
  output logic o_prot_enforced,
  output logic o_dl_mode,
  output logic o_stall
);
  logic [7:0] flash_mem [0:16383];
  logic dl_sync1;
  logic dl_sync2;
  fpp_pkg::fpp_byte_t flash_command_reg;
  fpp_pkg::fpp_byte_t flash_pointer_high;
  fpp_pkg::fpp_byte_t flash_pointer_low;
  fpp_pkg::fpp_byte_t wp_stage_mid;
  fpp_pkg::fpp_byte_t wp_stage_low;
  fpp_pkg::fpp_byte_t read_prot_stage;
  fpp_pkg::fpp_byte_t prot_key_reg;
  fpp_pkg::fpp_byte_t flash_access_key_reg;
  fpp_pkg::fpp_byte_t flash_data_reg;
  logic [31:0] act_wp;
  logic [7:0] act_rp;
  logic busy;
  logic enforced;
  logic go;
  logic [7:0] cmd;
  fpp_pkg::fpp_addr_t ptr;
  logic [4:0] page;
  logic wp_hit;
  logic rp_hit;
  logic key_ok;
  logic prot_ok;
  logic erase_job;
  logic load;
  logic [TW-1:0] next_cycles;

  // Download strap pin into the clock domain
  always_ff @(posedge i_clk)
  begin
    dl_sync1 <= bus.serial_dl_enable_n;
    dl_sync2 <= dl_sync1;
  end

  // Strap and protection state captured while reset is held
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_dl_mode <= ~dl_sync2;
      act_wp <= {flash_mem[`FPP_ADDR_WP_3], flash_mem[`FPP_ADDR_WP_2],
                 flash_mem[`FPP_ADDR_WP_1], flash_mem[`FPP_ADDR_WP_0]};
      act_rp <= flash_mem[`FPP_ADDR_RP];
      o_prot_enforced <= ~flash_mem[`FPP_ADDR_WP_3][7] & ~flash_mem[`FPP_ADDR_RP][7];
    end
  end

  assign enforced = o_prot_enforced;
  assign ptr = {flash_pointer_high[5:0], flash_pointer_low};
  assign page = ptr[13:9];
  assign wp_hit = enforced & ~act_wp[page];
  assign cmd = bus.sfr_wdata;
  assign go = bus.sfr_wr & ~busy & (bus.sfr_addr == `FPP_SFR_CMD) & (flash_access_key_reg == `FPP_ACCESS_KEY);
  assign key_ok = (flash_mem[`FPP_ADDR_KEY] == `FPP_ERASED) | (prot_key_reg == flash_mem[`FPP_ADDR_KEY]);
  assign prot_ok = go & (cmd == `FPP_CMD_PROTECT) & ~o_dl_mode & key_ok;
  assign erase_job = bus.mass_erase & ~busy;
  assign load = go | erase_job;

  // Stall time per command
  always_comb
  begin
    next_cycles = '0;
    if (erase_job)
      next_cycles = TW'(CYC_ALL);
    else
    begin
      case (cmd)
        `FPP_CMD_WRITE: next_cycles = TW'(`FPP_CYC_WRITE);
        `FPP_CMD_ERASE_PAGE: next_cycles = TW'(CYC_PAGE);
        `FPP_CMD_ERASE_ALL: next_cycles = TW'(CYC_ALL);
        `FPP_CMD_ERASE_WRITE: next_cycles = TW'(CYC_ERASE_WRITE);
        `FPP_CMD_READ: next_cycles = TW'(`FPP_CYC_READ);
        `FPP_CMD_VERIFY: next_cycles = TW'(`FPP_CYC_READ);
        `FPP_CMD_PROTECT: next_cycles = TW'(`FPP_CYC_PROTECT);
        default: next_cycles = '0;
      endcase
    end
  end

  fpp_busy_timer #(
    .WIDTH(TW)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(load),
    .i_cycles(next_cycles),
    .o_busy(busy)
  );

  assign o_stall = busy;
  assign bus.stall = busy;

  // Special function registers; writes ignored while stalled
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      flash_command_reg <= `FPP_SFR_RESET;
      flash_pointer_high <= `FPP_SFR_RESET;
      flash_pointer_low <= `FPP_SFR_RESET;
      wp_stage_mid <= `FPP_SFR_RESET;
      wp_stage_low <= `FPP_SFR_RESET;
      read_prot_stage <= `FPP_SFR_RESET;
      prot_key_reg <= `FPP_ERASED;
      flash_access_key_reg <= `FPP_SFR_RESET;
      flash_data_reg <= `FPP_SFR_RESET;
    end
    else if (bus.sfr_wr & ~busy)
    begin
      case (bus.sfr_addr)
        `FPP_SFR_CMD:
        begin
          flash_command_reg <= cmd;
          flash_access_key_reg <= `FPP_SFR_RESET;
          if (go & (cmd == `FPP_CMD_READ))
            flash_data_reg <= (rp_of(ptr) | o_dl_mode & rp_of(ptr)) ? `FPP_BLOCKED_DATA : flash_mem[ptr];
        end
        `FPP_SFR_PTR_HIGH: flash_pointer_high <= bus.sfr_wdata;
        `FPP_SFR_PTR_LOW: flash_pointer_low <= bus.sfr_wdata;
        `FPP_SFR_WP_MID: wp_stage_mid <= bus.sfr_wdata;
        `FPP_SFR_WP_LOW: wp_stage_low <= bus.sfr_wdata;
        `FPP_SFR_RD_PROT: read_prot_stage <= bus.sfr_wdata;
        `FPP_SFR_PROT_KEY: prot_key_reg <= bus.sfr_wdata;
        `FPP_SFR_ACC_KEY: flash_access_key_reg <= bus.sfr_wdata;
        `FPP_SFR_DATA: flash_data_reg <= bus.sfr_wdata;
        default: flash_data_reg <= flash_data_reg;
      endcase
    end
  end

  assign bus.flash_data = flash_data_reg;

  function automatic logic rp_of(input fpp_pkg::fpp_addr_t a);
    rp_of = enforced & ~act_rp[a[13:11]];
  endfunction

  // Flash array; protected pages keep their contents except on mass erase and when the protect command writes the protection bytes
  always_ff @(posedge i_clk)
  begin
    if (erase_job)
    begin
      for (int i = 0; i < 16384; i++)
        flash_mem[i] <= `FPP_ERASED;
    end
    else if (go)
    begin
      case (cmd)
        `FPP_CMD_WRITE:
          if (!wp_hit)
            flash_mem[ptr] <= flash_mem[ptr] & flash_data_reg;
        `FPP_CMD_ERASE_PAGE:
          if (!wp_hit)
          begin
            for (int i = 0; i < 512; i++)
              flash_mem[{page, 9'(i)}] <= `FPP_ERASED;
          end
        `FPP_CMD_ERASE_WRITE:
          if (!wp_hit)
          begin
            for (int i = 0; i < 512; i++)
              flash_mem[{page, 9'(i)}] <= (9'(i) == ptr[8:0]) ? flash_data_reg : `FPP_ERASED;
          end
        `FPP_CMD_ERASE_ALL:
          for (int i = 0; i < 16384; i++)
            if (!(enforced & ~act_wp[i / 512]))
              flash_mem[i] <= `FPP_ERASED;
        `FPP_CMD_PROTECT:
          if (prot_ok)
          begin
            flash_mem[`FPP_ADDR_WP_3] <= flash_mem[`FPP_ADDR_WP_3] & flash_pointer_high;
            flash_mem[`FPP_ADDR_WP_2] <= flash_mem[`FPP_ADDR_WP_2] & flash_pointer_low;
            flash_mem[`FPP_ADDR_WP_1] <= flash_mem[`FPP_ADDR_WP_1] & wp_stage_mid;
            flash_mem[`FPP_ADDR_WP_0] <= flash_mem[`FPP_ADDR_WP_0] & wp_stage_low;
            flash_mem[`FPP_ADDR_RP] <= flash_mem[`FPP_ADDR_RP] & read_prot_stage;
            if (flash_mem[`FPP_ADDR_KEY] == `FPP_ERASED)
              flash_mem[`FPP_ADDR_KEY] <= prot_key_reg;
          end
        default: flash_mem[ptr] <= flash_mem[ptr];
      endcase
    end
  end

  // Direct read port for code and emulation fetches
  assign rp_hit = rp_of(i_rd_addr);

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_rd_data <= `FPP_SFR_RESET;
      o_rd_blocked <= 1'b0;
    end
    else if (i_rd_en)
    begin
      o_rd_data <= rp_hit ? `FPP_BLOCKED_DATA : flash_mem[i_rd_addr];
      o_rd_blocked <= rp_hit;
    end
  end
endmodule // fpp_device

// >>> verilog/fpp_host.sv
// Download controller: Wishbone registers driving kernel commands onto the SFR link
`include "fpp_regs.svh"
`timescale 1ns/1ps
module fpp_host (
  input wire logic i_clk,
  input wire logic i_rst,
  fpp_if.host bus,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack
);
  fpp_pkg::fpp_host_state_t state;
  fpp_pkg::fpp_byte_t r0;
  logic bad_cmd;
  logic dl_req;
  logic req;
  logic wr;
  logic kcmd_ok;

  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = req & i_wb_we;
  assign kcmd_ok = wr & (i_wb_adr == `FPP_WB_KCMD) & (i_wb_sel[1:0] == 2'b11) & (state == fpp_pkg::FPP_H_IDLE)
                   & ~bus.stall;

  // Wishbone answer one cycle after the request
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= req;
      o_wb_dat <= 32'h0000_0000;
      if (req & ~i_wb_we)
      begin
        case (i_wb_adr)
          `FPP_WB_KCMD: o_wb_dat <= {24'h00_0000, r0};
          `FPP_WB_STATUS: o_wb_dat <= {29'h0000_0000, bad_cmd, ~bus.serial_dl_enable_n,
                                       (state != fpp_pkg::FPP_H_IDLE) | bus.stall};
          `FPP_WB_CTRL: o_wb_dat <= {31'h0000_0000, dl_req};
          `FPP_WB_DATA: o_wb_dat <= {24'h00_0000, bus.flash_data};
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control: download strap and mass erase pulse
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dl_req <= 1'b0;
      bus.serial_dl_enable_n <= 1'b1;
      bus.mass_erase <= 1'b0;
    end
    else
    begin
      bus.mass_erase <= 1'b0;
      bus.serial_dl_enable_n <= ~dl_req;
      if (wr & (i_wb_adr == `FPP_WB_CTRL) & i_wb_sel[0])
      begin
        dl_req <= i_wb_dat[0];
        bus.mass_erase <= i_wb_dat[1] & ~bus.stall;
      end
    end
  end

  // Kernel command execution
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= fpp_pkg::FPP_H_IDLE;
      r0 <= 8'h00;
      bad_cmd <= 1'b0;
      bus.sfr_wr <= 1'b0;
      bus.sfr_addr <= 8'h00;
      bus.sfr_wdata <= 8'h00;
    end
    else
    begin
      case (state)
        fpp_pkg::FPP_H_IDLE:
          if (kcmd_ok)
          begin
            bad_cmd <= 1'b0;
            case (i_wb_dat[15:8])
              `FPP_KCMD_LOAD: r0 <= i_wb_dat[7:0];
              `FPP_KCMD_STORE:
              begin
                bus.sfr_wr <= 1'b1;
                bus.sfr_addr <= i_wb_dat[7:0];
                bus.sfr_wdata <= r0;
                state <= fpp_pkg::FPP_H_ISSUE;
              end
              default: bad_cmd <= 1'b1;
            endcase
          end
        fpp_pkg::FPP_H_ISSUE:
        begin
          bus.sfr_wr <= 1'b0;
          state <= fpp_pkg::FPP_H_WAIT;
        end
        fpp_pkg::FPP_H_WAIT:
          if (!bus.stall)
            state <= fpp_pkg::FPP_H_IDLE;
        default: state <= fpp_pkg::FPP_H_IDLE;
      endcase
    end
  end
endmodule // fpp_host

// >>> sim/fpp_monitor.sv
// Checker for the SFR link between controller and device
`include "fpp_regs.svh"
`timescale 1ns/1ps
module fpp_monitor #(
  parameter int CYC_PAGE = 20,
  parameter int CYC_ALL = 40,
  parameter int CYC_ERASE_WRITE = 25
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic sfr_wr,
  input wire fpp_pkg::fpp_byte_t sfr_addr,
  input wire fpp_pkg::fpp_byte_t sfr_wdata,
  input wire fpp_pkg::fpp_byte_t flash_data,
  input wire logic stall,
  input wire logic mass_erase,
  input wire logic serial_dl_enable_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  int run_len;
  int exp_len;
  logic [7:0] last_cmd;
  logic [5:0] act_hist;
  always_ff @(posedge i_clk)
    run_len <= (i_rst || !stall) ? 0 : run_len + 1;
  always_ff @(posedge i_clk)
    act_hist <= i_rst ? 6'h00 : {act_hist[4:0], sfr_wr | mass_erase};
  // Last accepted command, mass erase excluded from length checks
  always_ff @(posedge i_clk)
  begin
    if (i_rst || mass_erase)
      last_cmd <= `FPP_ERASED;
    else if (sfr_wr && !stall && sfr_addr == `FPP_SFR_CMD)
      last_cmd <= sfr_wdata;
  end
  always_comb
    case (last_cmd)
      `FPP_CMD_WRITE: exp_len = `FPP_CYC_WRITE;
      `FPP_CMD_ERASE_PAGE: exp_len = CYC_PAGE;
      `FPP_CMD_ERASE_ALL: exp_len = CYC_ALL;
      `FPP_CMD_ERASE_WRITE: exp_len = CYC_ERASE_WRITE;
      `FPP_CMD_READ, `FPP_CMD_VERIFY: exp_len = `FPP_CYC_READ;
      `FPP_CMD_PROTECT: exp_len = `FPP_CYC_PROTECT;
      default: exp_len = 0;
    endcase
  pulse_sfr_a: assert property (sfr_wr |=> !sfr_wr)
    else $error("SFR strobe longer than one cycle");
  busy_quiet_a: assert property (stall |-> !sfr_wr)
    else $error("SFR write while stalled");
  erase_pulse_a: assert property (mass_erase |=> !mass_erase)
    else $error("Mass erase longer than one cycle");
  erase_idle_a: assert property (mass_erase |-> !stall)
    else $error("Mass erase while stalled");
  stall_cause_a: assert property ($rose(stall) |-> ($past(sfr_wr) && $past(sfr_addr) == `FPP_SFR_CMD)
    || $past(mass_erase))
    else $error("Stall without command write");
  stall_len_a: assert property ($fell(stall) && exp_len != 0 |-> run_len == exp_len)
    else $error("Stall length wrong");
  prot_hold_a: assert property ($rose(stall) && last_cmd == `FPP_CMD_PROTECT |-> stall[*8])
    else $error("Protect stall too short");
  read_len_a: assert property ($rose(stall) && last_cmd == `FPP_CMD_READ |=> !stall)
    else $error("Read stall not one cycle");
  data_cause_a: assert property ($changed(flash_data) |-> |act_hist)
    else $error("Flash data changed without access");
  cover property ($fell(stall) && last_cmd == `FPP_CMD_PROTECT);
  cover property ($rose(stall) && last_cmd == `FPP_CMD_READ);
  cover property (mass_erase);
  cover property ($fell(serial_dl_enable_n));
endmodule // fpp_monitor

// >>> sim/fpp_tb.sv
// Testbench driving controller registers and device read port
`include "fpp_regs.svh"
`timescale 1ns/1ps
module fpp_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  // Controller only reset at power-up so its download strap holds through chip resets
  logic host_rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_q;
  logic wb_ack;
  logic rd_en = 1'b0;
  logic [13:0] rd_addr = 14'h0000;
  logic [7:0] rd_data;
  logic rd_blk, enforced, dl_mode, dev_stall;
  logic [31:0] q;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;
  fpp_if bus_if();
  fpp_host i_fpp_host(.i_clk(i_clk), .i_rst(host_rst), .bus(bus_if), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat), .o_wb_dat(wb_q), .o_wb_ack(wb_ack));
  fpp_device #(.CYC_PAGE(20), .CYC_ALL(40), .CYC_ERASE_WRITE(25)) i_fpp_device(.i_clk(i_clk), .i_rst(i_rst),
    .bus(bus_if), .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_blocked(rd_blk),
    .o_prot_enforced(enforced), .o_dl_mode(dl_mode), .o_stall(dev_stall));
  fpp_monitor i_fpp_monitor(.i_clk(i_clk), .i_rst(i_rst),
    .sfr_wr(bus_if.sfr_wr), .sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata),
    .flash_data(bus_if.flash_data), .stall(bus_if.stall), .mass_erase(bus_if.mass_erase),
    .serial_dl_enable_n(bus_if.serial_dl_enable_n));

  always #50 i_clk = ~i_clk;

  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      wrap_up();
    end
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic single Wishbone cycle, result left in q
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hF;
    @(posedge i_clk);
    while (wb_ack !== 1'b1)
      @(posedge i_clk);
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge i_clk);
  endtask

  task idle();
    wb(1'b0, `FPP_WB_STATUS, 32'h0000_0000);
    while (q[0] !== 1'b0)
      wb(1'b0, `FPP_WB_STATUS, 32'h0000_0000);
  endtask

  task sfr(input logic [7:0] a, input logic [7:0] v);
    wb(1'b1, `FPP_WB_KCMD, {16'h0000, `FPP_KCMD_LOAD, v});
    wb(1'b1, `FPP_WB_KCMD, {16'h0000, `FPP_KCMD_STORE, a});
    idle();
  endtask

  task cmd(input logic [7:0] c);
    sfr(`FPP_SFR_ACC_KEY, `FPP_ACCESS_KEY);
    sfr(`FPP_SFR_CMD, c);
  endtask

  task prog(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] rp, input logic [7:0] key);
    sfr(`FPP_SFR_PTR_HIGH, hi);
    sfr(`FPP_SFR_PTR_LOW, lo);
    sfr(`FPP_SFR_WP_MID, 8'hFF);
    sfr(`FPP_SFR_WP_LOW, 8'hFF);
    sfr(`FPP_SFR_RD_PROT, rp);
    sfr(`FPP_SFR_PROT_KEY, key);
    cmd(`FPP_CMD_PROTECT);
  endtask

  task rd(input logic [13:0] a, input logic [7:0] d, input logic b);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge i_clk);
    rd_en <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("rd_data", {24'h0, rd_data}, {24'h0, d});
    chk("rd_blocked", {31'h0, rd_blk}, {31'h0, b});
  endtask

  task reset_all();
    i_rst <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
  endtask

  task done(input string s);
    $display("test %s finished, mismatches so far %0d", s, fails);
  endtask

  initial
  begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    host_rst <= 1'b0;
    @(posedge i_clk);
    wb(1'b0, `FPP_WB_STATUS, 32'h0000_0000);
    chk("status", q, 32'h0000_0000);
    wb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", q, 32'h0000_0000);
    wb(1'b1, `FPP_WB_KCMD, 32'h0000_5500);
    wb(1'b0, `FPP_WB_STATUS, 32'h0000_0000);
    chk("bad_cmd", {31'h0, q[2]}, 32'h0000_0001);
    wb(1'b1, `FPP_WB_KCMD, {16'h0000, `FPP_KCMD_LOAD, 8'hA5});
    wb(1'b0, `FPP_WB_KCMD, 32'h0000_0000);
    chk("r0", {24'h0, q[7:0]}, 32'h0000_00A5);
    done("kernel");
    wb(1'b1, `FPP_WB_CTRL, 32'h0000_0002);
    idle();
    reset_all();
    chk("enforced", {31'h0, enforced}, 32'h0000_0000);
    rd(14'h3FFF, 8'hFF, 1'b0);
    sfr(`FPP_SFR_PTR_HIGH, 8'h00);
    sfr(`FPP_SFR_PTR_LOW, 8'h00);
    cmd(`FPP_CMD_READ);
    wb(1'b0, `FPP_WB_DATA, 32'h0000_0000);
    chk("flash_data", {24'h0, q[7:0]}, 32'h0000_00FF);
    done("erase and read");
    sfr(`FPP_SFR_RD_PROT, 8'h00);
    wb(1'b1, `FPP_WB_KCMD, {16'h0000, `FPP_KCMD_LOAD, `FPP_CMD_PROTECT});
    wb(1'b1, `FPP_WB_KCMD, {16'h0000, `FPP_KCMD_STORE, `FPP_SFR_CMD});
    chk("stall", {31'h0, dev_stall}, 32'h0000_0000);
    idle();
    rd(14'h3FFB, 8'hFF, 1'b0);
    done("no access key");
    prog(8'h7F, 8'hFF, 8'h7F, 8'hA3);
    rd(14'h3FFF, 8'h7F, 1'b0);
    rd(14'h3FFC, 8'hFF, 1'b0);
    rd(14'h3FFB, 8'h7F, 1'b0);
    rd(14'h3FFA, 8'hA3, 1'b0);
    chk("enforced", {31'h0, enforced}, 32'h0000_0000);
    rd(14'h3E00, 8'hFF, 1'b0);
    reset_all();
    chk("enforced", {31'h0, enforced}, 32'h0000_0001);
    rd(14'h3E00, 8'h00, 1'b1);
    rd(14'h0000, 8'hFF, 1'b0);
    done("program");
    prog(8'h7F, 8'hFF, 8'h00, 8'hFF);
    reset_all();
    rd(14'h0000, 8'hFF, 1'b0);
    prog(8'h7F, 8'hFF, 8'hFE, 8'hA3);
    reset_all();
    rd(14'h0000, 8'h00, 1'b1);
    done("key");
    wb(1'b1, `FPP_WB_CTRL, 32'h0000_0002);
    idle();
    reset_all();
    chk("enforced", {31'h0, enforced}, 32'h0000_0000);
    rd(14'h0000, 8'hFF, 1'b0);
    done("mass erase");
    wb(1'b1, `FPP_WB_CTRL, 32'h0000_0001);
    repeat (3) @(posedge i_clk);
    reset_all();
    chk("dl_mode", {31'h0, dl_mode}, 32'h0000_0001);
    prog(8'h7F, 8'hFF, 8'h7F, 8'hFF);
    wb(1'b1, `FPP_WB_CTRL, 32'h0000_0000);
    repeat (3) @(posedge i_clk);
    reset_all();
    chk("dl_mode", {31'h0, dl_mode}, 32'h0000_0000);
    chk("enforced", {31'h0, enforced}, 32'h0000_0000);
    done("download");
    wrap_up();
  end
endmodule // fpp_tb
